// ==== verilog/gcr_pkg.sv ====
// global clock and reset control: shared constants and types
// assumes one 125 MHz clock and an APB register port with 32-bit data
package gcr_pkg;

  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_PIN_SEL = 10'h0F2;
  localparam logic [9:0] IDX_CLK_SRC = 10'h0F3;
  localparam logic [9:0] IDX_LU_RST = 10'h0F5;
  localparam logic [9:0] IDX_FR_RST = 10'h0F6;
  localparam logic [9:0] IDX_CHIP_ID = 10'h0F8;
  localparam logic [11:0] ADDR_PIN_SEL = {IDX_PIN_SEL, 2'h0};
  localparam logic [11:0] ADDR_CLK_SRC = {IDX_CLK_SRC, 2'h0};
  localparam logic [11:0] ADDR_LU_RST = {IDX_LU_RST, 2'h0};
  localparam logic [11:0] ADDR_FR_RST = {IDX_FR_RST, 2'h0};
  localparam logic [11:0] ADDR_CHIP_ID = {IDX_CHIP_ID, 2'h0};

  // reset values and writable masks
  localparam logic [7:0] PIN_SEL_RST = 8'h00;
  localparam logic [7:0] PIN_SEL_MASK = 8'h07;
  localparam logic [7:0] CLK_SRC_RST = 8'h00;
  localparam logic [3:0] SOFT_RST_RST = 4'h0;

  // pin select field positions
  localparam int POS_RX_SLOT = 0;
  localparam int POS_TX_DIR = 1;
  localparam int POS_LOSS_SEL = 2;

  // identification: part code value is arbitrary
  localparam logic [4:0] PART_CODE = 5'h15;
  localparam logic [2:0] SILICON_REV = 3'h0;

  // backplane reference select codes
  localparam logic [3:0] REF_MCLK_T1 = 4'h8;
  localparam logic [3:0] REF_MCLK_E1 = 4'h9;
  localparam logic [3:0] REF_EXT = 4'hA;

  // rates in kHz as printed; frame pulse at 8 kHz
  localparam longint CLK_KHZ = 125000;
  localparam longint REF_E1_KHZ = 2048;
  localparam longint REF_T1_KHZ = 1544;
  localparam longint FRAME_KHZ = 8;
  localparam logic [7:0] FRAME_LAST_E1 = 8'(REF_E1_KHZ / FRAME_KHZ - 1);
  localparam logic [7:0] FRAME_LAST_T1 = 8'(REF_T1_KHZ / FRAME_KHZ - 1);

  // accumulator steps: two toggles per reference period
  localparam logic [31:0] NCO_INC_E1 =
    32'(((2 * REF_E1_KHZ) << 32) / CLK_KHZ);
  localparam logic [31:0] NCO_INC_T1 =
    32'(((2 * REF_T1_KHZ) << 32) / CLK_KHZ);

  // clock source control register layout
  typedef struct packed {
    logic [3:0] refSel;
    logic rateSel;
    logic family;
    logic [1:0] mult;
  } gcr_clk_ctrl_t;

  typedef enum logic [1:0] {
    SRC_LINE = 2'h0,
    SRC_MCLK = 2'h1,
    SRC_EXT = 2'h3,
    SRC_NONE = 2'h2
  } gcr_ref_src_t;

endpackage : gcr_pkg

// ==== verilog/gcr_pin_sync.sv ====
// three-stage synchroniser for pin inputs, one lane per bit
// assumes inputs are asynchronous to clk; output moves when the last two stages agree
`timescale 1ns/10ps
module gcr_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic stage1;
      logic stage2;
      logic stage3;
      always_ff @(posedge clk) begin
        if (reset) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
          pinOut[i] <= 1'b0;
        end else begin
          stage1 <= pinIn[i];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            pinOut[i] <= stage3;
          end
        end
      end
    end
  endgenerate

endmodule : gcr_pin_sync

// ==== verilog/gcr_nco.sv ====
// phase accumulator producing a one-cycle tick at a programmed rate
// assumes step is stable while enabled; accumulator clears when idle
`timescale 1ns/10ps
module gcr_nco (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [31:0] step,
  output logic tick
);

  logic [31:0] phase;
  logic [32:0] sum;

  assign sum = {1'b0, phase} + {1'b0, step};

  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      phase <= 32'h0;
      tick <= 1'b0;
    end else begin
      phase <= sum[31:0];
      tick <= sum[32];
    end
  end

endmodule : gcr_nco

// ==== verilog/gcr_top.sv ====
// global clock and reset control: registers, pin muxes, backplane timing
// assumes an APB master on clk and pin inputs asynchronous to clk
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module gcr_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] rxChannelBlock,
  input wire logic [3:0] rxChannelClock,
  output logic [3:0] rxSlotPin,
  input wire logic [3:0] framerLos,
  input wire logic [3:0] lineUnitLos,
  output logic [3:0] alarmPin,
  input wire logic txFramePulseIn,
  output logic txFramePulseOut,
  output logic txFramePulseOe_n,
  output logic txFrameSync,
  input wire logic [3:0] rxLineClock,
  input wire logic referenceClockIn,
  output logic referenceClockOut,
  output logic referenceClockOe_n,
  output logic backplaneClockOut,
  input wire logic masterClockIn,
  output logic masterBaseTick,
  output gcr_pkg::gcr_clk_ctrl_t clkCtrl,
  output logic [3:0] lineUnitReset,
  output logic [3:0] framerReset
);
  import gcr_pkg::*;

  logic [7:0] pinSelect;
  logic [7:0] readByte;
  logic hit;
  logic setup;
  logic wrEn;
  logic [6:0] syncPins;
  gcr_ref_src_t refMode;
  logic derivedT1;
  logic ncoTick;
  logic derivedLevel;
  logic refLevel;
  logic refRise;
  logic frameRateT1;
  logic [7:0] frameLast;
  logic [7:0] frameCount;
  logic internalPulse;
  logic extPulseQ;
  logic extRise;
  logic masterQ;
  logic masterRise;
  logic [2:0] masterEdgeCount;
  logic [2:0] multMask;
  logic [1:0] lineSel;

  // register port: answer one cycle after setup
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      ADDR_PIN_SEL: readByte = pinSelect;
      ADDR_CLK_SRC: readByte = clkCtrl;
      ADDR_LU_RST: readByte = {4'h0, lineUnitReset};
      ADDR_FR_RST: readByte = {4'h0, framerReset};
      ADDR_CHIP_ID: readByte = {PART_CODE, SILICON_REV};
      default: begin
        readByte = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup) begin
        prdata <= {24'h0, readByte};
      end
    end
  end

  // writable control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      pinSelect <= PIN_SEL_RST;
    end else if (wrEn && paddr == ADDR_PIN_SEL) begin
      pinSelect <= pwdata[7:0] & PIN_SEL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clkCtrl <= CLK_SRC_RST;
    end else if (wrEn && paddr == ADDR_CLK_SRC) begin
      clkCtrl <= pwdata[7:0];
    end
  end

  // soft resets: set by writing 1, held until a 0 is written
  always_ff @(posedge clk) begin
    if (reset) begin
      lineUnitReset <= SOFT_RST_RST;
    end else if (wrEn && paddr == ADDR_LU_RST) begin
      lineUnitReset <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      framerReset <= SOFT_RST_RST;
    end else if (wrEn && paddr == ADDR_FR_RST) begin
      framerReset <= pwdata[3:0];
    end
  end

  // shared output pin functions
  always_ff @(posedge clk) begin
    if (reset) begin
      rxSlotPin <= 4'h0;
      alarmPin <= 4'h0;
    end else begin
      rxSlotPin <= pinSelect[POS_RX_SLOT] ? rxChannelClock
                                          : rxChannelBlock;
      alarmPin <= pinSelect[POS_LOSS_SEL] ? lineUnitLos
                                          : framerLos;
    end
  end

  // pin inputs: [0] frame pulse, [4:1] line clocks, [5] ref, [6] master
  gcr_pin_sync #(.W(7)) u_sync (
    .clk(clk),
    .reset(reset),
    .pinIn({masterClockIn, referenceClockIn, rxLineClock, txFramePulseIn}),
    .pinOut(syncPins)
  );

  // reference source decode
  always_comb begin
    lineSel = clkCtrl.refSel[1:0];
    if (clkCtrl.refSel[3:2] == 2'h0) begin
      refMode = SRC_LINE;
    end else if (clkCtrl.refSel == REF_MCLK_T1 ||
                 clkCtrl.refSel == REF_MCLK_E1) begin
      refMode = SRC_MCLK;
    end else if (clkCtrl.refSel == REF_EXT) begin
      refMode = SRC_EXT;
    end else begin
      refMode = SRC_NONE;
    end
  end

  assign derivedT1 = (clkCtrl.refSel == REF_MCLK_T1);

  gcr_nco u_nco (
    .clk(clk),
    .reset(reset),
    .enable(refMode == SRC_MCLK),
    .step(derivedT1 ? NCO_INC_T1 : NCO_INC_E1),
    .tick(ncoTick)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      derivedLevel <= 1'b0;
    end else if (ncoTick) begin
      derivedLevel <= ~derivedLevel;
    end
  end

  always_comb begin
    unique case (refMode)
      SRC_LINE: refLevel = syncPins[3'(lineSel) + 3'h1];
      SRC_MCLK: refLevel = derivedLevel;
      SRC_EXT: refLevel = syncPins[5];
      SRC_NONE: refLevel = backplaneClockOut;
    endcase
  end

  assign refRise = refLevel & ~backplaneClockOut;

  // reference pin drives only in derived mode
  always_ff @(posedge clk) begin
    if (reset) begin
      backplaneClockOut <= 1'b0;
      referenceClockOut <= 1'b0;
      referenceClockOe_n <= 1'b1;
    end else begin
      backplaneClockOut <= refLevel;
      referenceClockOut <= derivedLevel;
      referenceClockOe_n <= (refMode != SRC_MCLK);
    end
  end

  // 8 kHz frame timing counted in reference periods
  assign frameRateT1 = (refMode == SRC_MCLK) ? derivedT1
                                             : clkCtrl.rateSel;
  assign frameLast = frameRateT1 ? FRAME_LAST_T1 : FRAME_LAST_E1;
  assign extRise = syncPins[0] & ~extPulseQ;

  always_ff @(posedge clk) begin
    if (reset) begin
      extPulseQ <= 1'b0;
    end else begin
      extPulseQ <= syncPins[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frameCount <= 8'h00;
    end else if (!pinSelect[POS_TX_DIR] && extRise) begin
      frameCount <= 8'h00;
    end else if (refRise) begin
      if (frameCount >= frameLast) begin
        frameCount <= 8'h00;
      end else begin
        frameCount <= frameCount + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      internalPulse <= 1'b0;
    end else if (refRise) begin
      internalPulse <= (frameCount == frameLast);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txFramePulseOut <= 1'b0;
      txFramePulseOe_n <= 1'b1;
      txFrameSync <= 1'b0;
    end else begin
      txFramePulseOut <= internalPulse;
      txFramePulseOe_n <= ~pinSelect[POS_TX_DIR];
      txFrameSync <= pinSelect[POS_TX_DIR] ? internalPulse
                                           : syncPins[0];
    end
  end

  // master clock: divide edges by the multiple to get base-rate ticks
  always_comb begin
    unique case (clkCtrl.mult)
      2'h0: multMask = 3'h0;
      2'h1: multMask = 3'h1;
      2'h2: multMask = 3'h3;
      2'h3: multMask = 3'h7;
    endcase
  end

  assign masterRise = syncPins[6] & ~masterQ;

  always_ff @(posedge clk) begin
    if (reset) begin
      masterQ <= 1'b0;
      masterEdgeCount <= 3'h0;
      masterBaseTick <= 1'b0;
    end else begin
      masterQ <= syncPins[6];
      if (masterRise) begin
        masterEdgeCount <= masterEdgeCount + 3'h1;
      end
      masterBaseTick <= masterRise &&
        ((masterEdgeCount & multMask) == multMask);
    end
  end

  // checks
  a_rx_slot_mux: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> rxSlotPin == ($past(pinSelect[POS_RX_SLOT]) ?
      $past(rxChannelClock) : $past(rxChannelBlock)))
    else $error("receive slot pins carry the wrong source");

  a_alarm_source: assert property (@(posedge clk) disable iff (reset)
    $past(pinSelect[POS_LOSS_SEL]) && !$past(reset)
      |-> alarmPin == $past(lineUnitLos))
    else $error("alarm pins not from line-unit loss");

  a_tx_pin_dir: assert property (@(posedge clk) disable iff (reset)
    wrEn && paddr == ADDR_PIN_SEL && pwdata[POS_TX_DIR]
      |=> ##1 !txFramePulseOe_n)
    else $error("frame pulse pin not driven after direction set");

  a_frame_period: assert property (@(posedge clk) disable iff (reset)
    $rose(internalPulse) |-> $past(frameCount) == $past(frameLast))
    else $error("frame pulse at wrong count");

  a_line_ref: assert property (@(posedge clk) disable iff (reset)
    refMode == SRC_LINE |=> backplaneClockOut ==
      $past(syncPins[3'(lineSel) + 3'h1]))
    else $error("backplane clock not following line clock");

  a_ref_drive: assert property (@(posedge clk) disable iff (reset)
    (refMode == SRC_MCLK) [*2] |-> !referenceClockOe_n)
    else $error("reference pin not driven in derived mode");

  a_ref_input: assert property (@(posedge clk) disable iff (reset)
    refMode == SRC_EXT |=> referenceClockOe_n)
    else $error("reference pin driven in external mode");

  a_reserved_hold: assert property (@(posedge clk) disable iff (reset)
    refMode == SRC_NONE ##1 refMode == SRC_NONE
      |-> $stable(backplaneClockOut) && referenceClockOe_n)
    else $error("backplane clock moved under reserved code");

  a_lu_reset_set: assert property (@(posedge clk) disable iff (reset)
    wrEn && paddr == ADDR_LU_RST && pwdata[0] |=> lineUnitReset[0])
    else $error("line-unit reset not taken");

  a_fr_reset_set: assert property (@(posedge clk) disable iff (reset)
    wrEn && paddr == ADDR_FR_RST && pwdata[3] |=> framerReset[3])
    else $error("framer reset not taken");

  a_reset_hold: assert property (@(posedge clk) disable iff (reset)
    lineUnitReset[1] && !(wrEn && paddr == ADDR_LU_RST)
      |=> lineUnitReset[1])
    else $error("soft reset released without a write");

  a_id_value: assert property (@(posedge clk) disable iff (reset)
    setup && paddr == ADDR_CHIP_ID |=> prdata[7:3] == PART_CODE &&
      !pslverr)
    else $error("part code field wrong");

  a_id_rev: assert property (@(posedge clk) disable iff (reset)
    setup && paddr == ADDR_CHIP_ID |=> prdata[2:0] == 3'h0)
    else $error("revision field wrong");

  a_upper_zero: assert property (@(posedge clk) disable iff (reset)
    setup && paddr == ADDR_FR_RST |=> prdata[31:4] == 28'h0)
    else $error("unused reset bits read nonzero");

  a_master_tick: assert property (@(posedge clk) disable iff (reset)
    masterBaseTick |-> $past(masterRise) &&
      ($past(masterEdgeCount) & $past(multMask)) == $past(multMask))
    else $error("master base tick off multiple");

  a_family_kept: assert property (@(posedge clk) disable iff (reset)
    !(wrEn && paddr == ADDR_CLK_SRC) |=> $stable(clkCtrl.family))
    else $error("master family changed without a write");

endmodule : gcr_top

// ==== sim/tb.sv ====
// self-checking bench for the global clock and reset control block
// assumes gcr_pkg and gcr_top are compiled first; drives every input
`timescale 1ns/10ps
module tb;
  import gcr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [3:0] rxChannelBlock = 4'h0;
  logic [3:0] rxChannelClock = 4'h0;
  logic [3:0] framerLos = 4'h0;
  logic [3:0] lineUnitLos = 4'h0;
  logic [3:0] rxLineClock = 4'h0;
  logic [3:0] rxSlotPin, alarmPin, lineUnitReset, framerReset;
  logic txFramePulseIn = 1'b0;
  logic referenceClockIn = 1'b0;
  logic txFramePulseOut, txFramePulseOe_n, txFrameSync;
  logic referenceClockOut, referenceClockOe_n, backplaneClockOut;
  logic masterBaseTick;
  logic [2:0] masterDiv = 3'h0;
  logic masterClockIn;
  gcr_clk_ctrl_t clkCtrl;
  int nErrors = 0;
  int nCompared = 0;

  always #4 clk = ~clk;
  // master clock pin: one period every 8 cycles
  always @(posedge clk) masterDiv <= masterDiv + 3'h1;
  assign masterClockIn = masterDiv[2];

  gcr_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxChannelBlock(rxChannelBlock), .rxChannelClock(rxChannelClock),
    .rxSlotPin(rxSlotPin), .framerLos(framerLos),
    .lineUnitLos(lineUnitLos), .alarmPin(alarmPin),
    .txFramePulseIn(txFramePulseIn), .txFramePulseOut(txFramePulseOut),
    .txFramePulseOe_n(txFramePulseOe_n), .txFrameSync(txFrameSync),
    .rxLineClock(rxLineClock), .referenceClockIn(referenceClockIn),
    .referenceClockOut(referenceClockOut),
    .referenceClockOe_n(referenceClockOe_n),
    .backplaneClockOut(backplaneClockOut), .masterClockIn(masterClockIn),
    .masterBaseTick(masterBaseTick), .clkCtrl(clkCtrl),
    .lineUnitReset(lineUnitReset), .framerReset(framerReset));

  task print_verdict;
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic give_up(input string what);
    nErrors++;
    $display("timeout waiting for %s", what);
    print_verdict();
  endtask : give_up

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one APB transfer; answer taken at the rising edge that completes it
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [7:0] data, input logic [3:0] strb,
                     output logic [31:0] rdata, output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0, data};
    pstrb <= strb;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) give_up("pready");
    rdata = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] addr, input logic [7:0] data);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, data, 4'hF, d, e);
  endtask : wr

  task automatic rd_check(input string name, input logic [11:0] addr,
                          input logic [7:0] exp, input logic expErr);
    logic [31:0] d;
    logic e;
    apb(1'b0, addr, 8'h00, 4'h0, d, e);
    check(name, d, {24'h0, exp});
    check({name, " error"}, e, expErr);
  endtask : rd_check

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // cycles between two rising edges: 0 ref out, 1 base tick, 2 frame sync
  task automatic period(input int sel, input int bound, output int cycles);
    int i;
    logic prev, cur, started;
    prev = 1'b1;
    started = 1'b0;
    cycles = 0;
    for (i = 0; i < 2 * bound; i++) begin
      @(negedge clk);
      cur = (sel == 0) ? referenceClockOut :
            (sel == 1) ? masterBaseTick : txFrameSync;
      if (started) cycles++;
      if (cur === 1'b1 && prev === 1'b0) begin
        if (started) return;
        started = 1'b1;
      end
      prev = cur;
    end
    give_up("periodic edge");
  endtask : period

  initial begin
    logic [31:0] d;
    logic e;
    int k, pr, p0, p3;
    logic [3:0] resv [4];
    resv = '{4'h4, 4'h7, 4'hB, 4'hF};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check("tx sync enable", txFramePulseOe_n, 1'b1);
    check("ref pin enable", referenceClockOe_n, 1'b1);
    rd_check("pin select", ADDR_PIN_SEL, 8'h00, 1'b0);
    rd_check("clock source", ADDR_CLK_SRC, 8'h00, 1'b0);
    rd_check("lu resets", ADDR_LU_RST, 8'h00, 1'b0);
    rd_check("fr resets", ADDR_FR_RST, 8'h00, 1'b0);
    rd_check("identity", ADDR_CHIP_ID, {PART_CODE, 3'h0}, 1'b0);
    $display("test reset values done");

    wr(ADDR_PIN_SEL, 8'hFF);
    rd_check("pin select mask", ADDR_PIN_SEL, 8'h07, 1'b0);
    wr(ADDR_LU_RST, 8'hFF);
    rd_check("lu mask", ADDR_LU_RST, 8'h0F, 1'b0);
    wr(ADDR_FR_RST, 8'hF0);
    rd_check("fr mask", ADDR_FR_RST, 8'h00, 1'b0);
    wr(ADDR_CHIP_ID, 8'h00);
    rd_check("identity kept", ADDR_CHIP_ID, {PART_CODE, 3'h0}, 1'b0);
    apb(1'b1, ADDR_CLK_SRC, 8'h5A, 4'hE, d, e);
    rd_check("no strobe", ADDR_CLK_SRC, 8'h00, 1'b0);
    rd_check("unmapped", 12'h3D0, 8'h00, 1'b1);
    wr(ADDR_CLK_SRC, 8'hA5);
    rd_check("clock source rw", ADDR_CLK_SRC, 8'hA5, 1'b0);
    check("clkCtrl", clkCtrl, 8'hA5);
    wr(ADDR_LU_RST, 8'h00);
    $display("test access kinds done");

    rxChannelBlock <= 4'hA;
    rxChannelClock <= 4'h5;
    framerLos <= 4'h3;
    lineUnitLos <= 4'hC;
    for (k = 0; k < 4; k++) begin
      wr(ADDR_PIN_SEL, {5'h0, k[1], 1'b0, k[0]});
      settle(2);
      check("rx slot pins", rxSlotPin, k[0] ? 4'h5 : 4'hA);
      check("alarm pins", alarmPin, k[1] ? 4'hC : 4'h3);
    end
    $display("test pin functions done");

    wr(ADDR_LU_RST, 8'h05);
    settle(0);
    check("lu reset set", lineUnitReset, 4'h5);
    check("fr untouched", framerReset, 4'h0);
    wr(ADDR_FR_RST, 8'h0A);
    wr(ADDR_LU_RST, 8'h05);
    settle(0);
    check("fr reset set", framerReset, 4'hA);
    check("lu reset held", lineUnitReset, 4'h5);
    wr(ADDR_LU_RST, 8'h04);
    settle(0);
    check("lu one released", lineUnitReset, 4'h4);
    wr(ADDR_LU_RST, 8'h00);
    wr(ADDR_FR_RST, 8'h00);
    settle(0);
    check("lu released", lineUnitReset, 4'h0);
    check("fr released", framerReset, 4'h0);
    $display("test soft resets done");

    for (k = 0; k < 4; k++) begin
      wr(ADDR_CLK_SRC, {k[3:0], 4'h8});
      rxLineClock <= ~(4'h1 << k);
      settle(8);
      check("line ref low", backplaneClockOut, 1'b0);
      @(posedge clk);
      rxLineClock <= 4'h1 << k;
      settle(8);
      check("line ref high", backplaneClockOut, 1'b1);
      check("line ref pin", referenceClockOe_n, 1'b1);
    end
    wr(ADDR_CLK_SRC, 8'hA8);
    referenceClockIn <= 1'b1;
    rxLineClock <= 4'h0;
    settle(8);
    check("ext ref high", backplaneClockOut, 1'b1);
    check("ext ref pin", referenceClockOe_n, 1'b1);
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CLK_SRC, {resv[k], 4'h0});
      referenceClockIn <= k[0];
      rxLineClock <= {4{k[0]}};
      settle(8);
      check("reserved hold", backplaneClockOut, 1'b1);
      check("reserved pin", referenceClockOe_n, 1'b1);
    end
    wr(ADDR_CLK_SRC, 8'h90);
    settle(200);
    check("e1 ref pin", referenceClockOe_n, 1'b0);
    period(0, 200, pr);
    check("e1 ref period", pr >= 60 && pr <= 62, 1'b1);
    wr(ADDR_CLK_SRC, 8'h88);
    settle(200);
    period(0, 200, pr);
    check("t1 ref period", pr >= 80 && pr <= 82, 1'b1);
    $display("test reference select done");

    wr(ADDR_CLK_SRC, 8'h90);
    wr(ADDR_PIN_SEL, 8'h02);
    settle(1);
    check("tx sync drive", txFramePulseOe_n, 1'b0);
    period(2, 20000, pr);
    check("tx pulse out", txFramePulseOut, 1'b1);
    check("frame period", pr >= 15560 && pr <= 15690, 1'b1);
    wr(ADDR_PIN_SEL, 8'h00);
    settle(1);
    check("tx sync input", txFramePulseOe_n, 1'b1);
    @(posedge clk);
    txFramePulseIn <= 1'b1;
    settle(8);
    check("ext frame high", txFrameSync, 1'b1);
    @(posedge clk);
    txFramePulseIn <= 1'b0;
    settle(8);
    check("ext frame low", txFrameSync, 1'b0);
    $display("test frame pulse done");

    wr(ADDR_CLK_SRC, 8'h00);
    period(1, 500, p0);
    period(1, 500, p0);
    wr(ADDR_CLK_SRC, 8'h07);
    period(1, 2000, p3);
    period(1, 2000, p3);
    check("multiplier ratio", p3, p0 * 8);
    check("family bit", clkCtrl.family, 1'b1);
    $display("test master clock done");
    print_verdict();
  end
endmodule : tb
